// ===== design/gpc_pkg.sv
// Package with register map, field layout and reset values of the pad configuration block.
//
// How it works
// - Each first-group pin keeps the low bit of its drive code in the first drive register.
// - Each first-group pin keeps the high bit of its drive code in the second drive register.
// - The two drive bits of a pin decode to 2 mA, 4 mA, 8 mA or 12 mA at the pad.
// - Second-group drive low bits are a 15-bit field that resets to all ones (7fff).
// - Second-group drive high bits are a 15-bit field that resets to zero.
// - First-group slew bits select slow (0) or fast (1) and reset to zero.
// - Second-group slew bits select slow (0) or fast (1) and reset to zero.
// - Bit 15 of the first slew register picks the first-group and reset pad supply level.
// - Bit 15 of the second slew register picks the second-group pad supply level.
package gpc_pkg;
	// ========================================
	// Register offsets
	localparam logic [15:0] OFS_G1_DRV_LO = 16'hfa70;
	localparam logic [15:0] OFS_G1_DRV_HI = 16'hfa71;
	localparam logic [15:0] OFS_G1_SLEW = 16'hfa72;
	localparam logic [15:0] OFS_G2_DRV_LO = 16'hfa74;
	localparam logic [15:0] OFS_G2_DRV_HI = 16'hfa75;
	localparam logic [15:0] OFS_G2_SLEW = 16'hfa76;

	// ========================================
	// Field layout and reset values
	localparam int G1_PINS = 14;
	localparam int G2_PINS = 15;
	localparam int SUPPLY_BIT = 15;
	localparam logic [15:0] RST_G1_DRV_LO = 16'h0000;
	localparam logic [15:0] RST_G1_DRV_HI = 16'h0000;
	localparam logic [15:0] RST_G1_SLEW = 16'h0000;
	localparam logic [15:0] RST_G2_DRV_LO = 16'h7fff;
	localparam logic [15:0] RST_G2_DRV_HI = 16'h0000;
	localparam logic [15:0] RST_G2_SLEW = 16'h0000;
	localparam logic [15:0] MASK_G1_DRV = 16'h3fff;
	localparam logic [15:0] MASK_G1_SLEW = 16'hbfff;
	localparam logic [15:0] MASK_G2_DRV = 16'h7fff;
	localparam logic [15:0] MASK_G2_SLEW = 16'hffff;

	// One-hot drive strength select presented to a pad: bit 0 2 mA, 1 4 mA, 2 8 mA, 3 12 mA.
	localparam logic [3:0] SEL_2MA = 4'h1;
	localparam logic [3:0] SEL_4MA = 4'h2;
	localparam logic [3:0] SEL_8MA = 4'h4;
	localparam logic [3:0] SEL_12MA = 4'h8;

	typedef struct packed {
		logic [15:0] g1_drv_lo;
		logic [15:0] g1_drv_hi;
		logic [15:0] g1_slew;
		logic [15:0] g2_drv_lo;
		logic [15:0] g2_drv_hi;
		logic [15:0] g2_slew;
	} gpc_regs_t;

	localparam gpc_regs_t RST_REGS = '{RST_G1_DRV_LO, RST_G1_DRV_HI, RST_G1_SLEW,
		RST_G2_DRV_LO, RST_G2_DRV_HI, RST_G2_SLEW};
endpackage : gpc_pkg

// ===== design/gpc_pad_config_regs.sv
// Pad configuration register bank for two GPIO pad groups.
`timescale 1ns/10ps
module gpc_pad_config_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Register port
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Pad controls, one-hot drive select per pin
	output logic [gpc_pkg::G1_PINS*4-1:0] g1_drive_sel,
	output logic [gpc_pkg::G2_PINS*4-1:0] g2_drive_sel,
	output logic [gpc_pkg::G1_PINS-1:0] g1_slew_fast,
	output logic [gpc_pkg::G2_PINS-1:0] g2_slew_fast,
	output logic g1_supply_level_select,
	output logic g2_supply_level_select
);
	// ========================================
	// Address decode
	// One select line per register. An unmapped address raises none of them, so a write
	// there is dropped and a read there returns zero with no further logic.
	// The same selects serve both the write path and the read path.
	logic hit_g1_drv_lo;
	logic hit_g1_drv_hi;
	logic hit_g1_slew;
	logic hit_g2_drv_lo;
	logic hit_g2_drv_hi;
	logic hit_g2_slew;

	always_comb begin
		hit_g1_drv_lo = 1'b0;
		hit_g1_drv_hi = 1'b0;
		hit_g1_slew = 1'b0;
		hit_g2_drv_lo = 1'b0;
		hit_g2_drv_hi = 1'b0;
		hit_g2_slew = 1'b0;
		unique case (reg_addr)
			gpc_pkg::OFS_G1_DRV_LO: begin
				hit_g1_drv_lo = 1'b1;
			end
			gpc_pkg::OFS_G1_DRV_HI: begin
				hit_g1_drv_hi = 1'b1;
			end
			gpc_pkg::OFS_G1_SLEW: begin
				hit_g1_slew = 1'b1;
			end
			gpc_pkg::OFS_G2_DRV_LO: begin
				hit_g2_drv_lo = 1'b1;
			end
			gpc_pkg::OFS_G2_DRV_HI: begin
				hit_g2_drv_hi = 1'b1;
			end
			gpc_pkg::OFS_G2_SLEW: begin
				hit_g2_slew = 1'b1;
			end
			default: begin
			end
		endcase
	end

	// ========================================
	// Write enables
	// A strobe is qualified only by its own address select, so writes may follow each other
	// or a read with no idle cycle between them.
	logic we_g1_drv_lo;
	logic we_g1_drv_hi;
	logic we_g1_slew;
	logic we_g2_drv_lo;
	logic we_g2_drv_hi;
	logic we_g2_slew;

	assign we_g1_drv_lo = reg_wr & hit_g1_drv_lo;
	assign we_g1_drv_hi = reg_wr & hit_g1_drv_hi;
	assign we_g1_slew = reg_wr & hit_g1_slew;
	assign we_g2_drv_lo = reg_wr & hit_g2_drv_lo;
	assign we_g2_drv_hi = reg_wr & hit_g2_drv_hi;
	assign we_g2_slew = reg_wr & hit_g2_slew;

	// ========================================
	// Write data masks
	// Reserved positions are cleared before a word reaches its register. They then hold zero
	// and read back as zero with no mask on the read path.
	logic [15:0] wdata_g1_drv;
	logic [15:0] wdata_g1_slew;
	logic [15:0] wdata_g2_drv;
	logic [15:0] wdata_g2_slew;

	always_comb begin
		wdata_g1_drv = reg_wdata & gpc_pkg::MASK_G1_DRV;
		wdata_g1_slew = reg_wdata & gpc_pkg::MASK_G1_SLEW;
		wdata_g2_drv = reg_wdata & gpc_pkg::MASK_G2_DRV;
		wdata_g2_slew = reg_wdata & gpc_pkg::MASK_G2_SLEW;
	end

	// ========================================
	// Register file
	// A write lands on the edge that takes it, so a read in the very next cycle already sees
	// the new word.
	// Reset restores every register at once, the all-ones group 2 low drive word included.
	gpc_pkg::gpc_regs_t regs;
	gpc_pkg::gpc_regs_t next_regs;

	always_comb begin
		next_regs = regs;
		if (we_g1_drv_lo) begin
			next_regs.g1_drv_lo = wdata_g1_drv;
		end
		if (we_g1_drv_hi) begin
			next_regs.g1_drv_hi = wdata_g1_drv;
		end
		if (we_g1_slew) begin
			next_regs.g1_slew = wdata_g1_slew;
		end
		if (we_g2_drv_lo) begin
			next_regs.g2_drv_lo = wdata_g2_drv;
		end
		if (we_g2_drv_hi) begin
			next_regs.g2_drv_hi = wdata_g2_drv;
		end
		if (we_g2_slew) begin
			next_regs.g2_slew = wdata_g2_slew;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			regs <= gpc_pkg::RST_REGS;
		end else begin
			regs <= next_regs;
		end
	end

	// ========================================
	// Read enables
	// A read changes no register, so software may poll any address at any rate.
	logic re_g1_drv_lo;
	logic re_g1_drv_hi;
	logic re_g1_slew;
	logic re_g2_drv_lo;
	logic re_g2_drv_hi;
	logic re_g2_slew;

	assign re_g1_drv_lo = reg_rd & hit_g1_drv_lo;
	assign re_g1_drv_hi = reg_rd & hit_g1_drv_hi;
	assign re_g1_slew = reg_rd & hit_g1_slew;
	assign re_g2_drv_lo = reg_rd & hit_g2_drv_lo;
	assign re_g2_drv_hi = reg_rd & hit_g2_drv_hi;
	assign re_g2_slew = reg_rd & hit_g2_slew;

	// ========================================
	// Read data
	// The port returns zero in every cycle that does not follow a read, so a stale word never
	// looks like a fresh answer.
	// Only one select can be high, so the order of the tests below does not matter.
	logic [15:0] next_rdata;

	always_comb begin
		next_rdata = 16'h0000;
		if (re_g1_drv_lo) begin
			next_rdata = regs.g1_drv_lo;
		end
		if (re_g1_drv_hi) begin
			next_rdata = regs.g1_drv_hi;
		end
		if (re_g1_slew) begin
			next_rdata = regs.g1_slew;
		end
		if (re_g2_drv_lo) begin
			next_rdata = regs.g2_drv_lo;
		end
		if (re_g2_drv_hi) begin
			next_rdata = regs.g2_drv_hi;
		end
		if (re_g2_slew) begin
			next_rdata = regs.g2_slew;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	// ========================================
	// Drive strength decode
	// The pad cell wants a one-hot select, so the two stored bits of each pin are decoded
	// here rather than inside the pad ring.
	function automatic logic [3:0] decode_drive(input logic hi, input logic lo);
		logic [3:0] sel;
		sel = gpc_pkg::SEL_2MA;
		unique case ({hi, lo})
			2'b00: begin
				sel = gpc_pkg::SEL_2MA;
			end
			2'b01: begin
				sel = gpc_pkg::SEL_4MA;
			end
			2'b10: begin
				sel = gpc_pkg::SEL_8MA;
			end
			2'b11: begin
				sel = gpc_pkg::SEL_12MA;
			end
		endcase
		return sel;
	endfunction : decode_drive

	// Decoded from the next register values, so each pad select changes on the same edge as
	// the register bits behind it.
	logic [gpc_pkg::G1_PINS*4-1:0] next_g1_sel;
	logic [gpc_pkg::G2_PINS*4-1:0] next_g2_sel;

	// Group 2 has one pin more than group 1, so the loop runs over group 2.
	genvar i;
	generate
		for (i = 0; i < gpc_pkg::G2_PINS; i++) begin : g_pin
			logic g2_hi;
			logic g2_lo;
			assign g2_hi = next_regs.g2_drv_hi[i];
			assign g2_lo = next_regs.g2_drv_lo[i];
			assign next_g2_sel[i*4 +: 4] = decode_drive(g2_hi, g2_lo);
			if (i < gpc_pkg::G1_PINS) begin : g_g1
				logic g1_hi;
				logic g1_lo;
				assign g1_hi = next_regs.g1_drv_hi[i];
				assign g1_lo = next_regs.g1_drv_lo[i];
				assign next_g1_sel[i*4 +: 4] = decode_drive(g1_hi, g1_lo);
			end
		end
	endgenerate

	// ========================================
	// Group 1 drive select
	// Pin selects leave reset at 2 mA, the code held by two all-zero drive registers.
	always_ff @(posedge clk) begin
		if (srst) begin
			g1_drive_sel <= {gpc_pkg::G1_PINS{gpc_pkg::SEL_2MA}};
		end else begin
			g1_drive_sel <= next_g1_sel;
		end
	end

	// ========================================
	// Group 1 slew and supply
	// Bit 15 also sets the rail of the reset pad, which shares the group 1 supply.
	// The reserved bit 14 is not brought out.
	logic [gpc_pkg::G1_PINS-1:0] next_g1_slew_fast;
	logic next_g1_supply;

	always_comb begin
		next_g1_slew_fast = next_regs.g1_slew[gpc_pkg::G1_PINS-1:0];
		next_g1_supply = next_regs.g1_slew[gpc_pkg::SUPPLY_BIT];
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			g1_slew_fast <= '0;
			g1_supply_level_select <= 1'b0;
		end else begin
			g1_slew_fast <= next_g1_slew_fast;
			g1_supply_level_select <= next_g1_supply;
		end
	end

	// ========================================
	// Group 2 drive select
	// The low drive bits reset to ones, so group 2 leaves reset at 4 mA rather than 2 mA.
	// Software that wants 2 mA there must clear the low drive register first.
	always_ff @(posedge clk) begin
		if (srst) begin
			g2_drive_sel <= {gpc_pkg::G2_PINS{gpc_pkg::SEL_4MA}};
		end else begin
			g2_drive_sel <= next_g2_sel;
		end
	end

	// ========================================
	// Group 2 slew and supply
	// Bit 14 belongs to the slew field here, so this register has no reserved bit.
	logic [gpc_pkg::G2_PINS-1:0] next_g2_slew_fast;
	logic next_g2_supply;

	always_comb begin
		next_g2_slew_fast = next_regs.g2_slew[gpc_pkg::G2_PINS-1:0];
		next_g2_supply = next_regs.g2_slew[gpc_pkg::SUPPLY_BIT];
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			g2_slew_fast <= '0;
			g2_supply_level_select <= 1'b0;
		end else begin
			g2_slew_fast <= next_g2_slew_fast;
			g2_supply_level_select <= next_g2_supply;
		end
	end
endmodule : gpc_pad_config_regs

// ===== dv/gpc_regs_asserts.sv
// Checker for the pad configuration register bank.
`timescale 1ns/10ps
module gpc_regs_asserts (
	// Clock, reset and register port
	input wire logic clk,
	input wire logic srst,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// Pad controls
	input wire logic [55:0] g1_drive_sel,
	input wire logic [59:0] g2_drive_sel,
	input wire logic [13:0] g1_slew_fast,
	input wire logic [14:0] g2_slew_fast,
	input wire logic g1_supply_level_select,
	input wire logic g2_supply_level_select
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	rd_idle_zero_a: assert property (!reg_rd |=> reg_rdata == 16'h0) else $error("rdata");
	rst_pads_a: assert property ($fell(srst) |-> g2_drive_sel == {15{4'h2}}) else $error("g2");
	g1_slew_wr_a: assert property (reg_wr && reg_addr == 16'hfa72 |=>
		{g1_supply_level_select, 1'b0, g1_slew_fast} == ($past(reg_wdata) & 16'hbfff))
		else $error("g1 slew");
	g2_slew_wr_a: assert property (reg_wr && reg_addr == 16'hfa76 |=>
		{g2_supply_level_select, g2_slew_fast} == $past(reg_wdata)) else $error("g2 slew");
	slew_hold_a: assert property (!reg_wr |=> $stable(g1_slew_fast)) else $error("hold");
	drv_onehot_a: assert property ($onehot(g1_drive_sel[3:0])) else $error("onehot");
	resv_read_a: assert property (reg_rd && reg_addr == 16'hfa72 |=> !reg_rdata[14]) else $error("r");
	g2_slew_rd_a: assert property (reg_rd && reg_addr == 16'hfa76 |=>
		reg_rdata == {$past(g2_supply_level_select), $past(g2_slew_fast)}) else $error("g2 rd");
	cover property (reg_wr && reg_addr == 16'hfa74);
	cover property ($rose(g1_supply_level_select));
	cover property ($fell(g2_supply_level_select));
endmodule : gpc_regs_asserts
bind gpc_pad_config_regs gpc_regs_asserts u_chk (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .g1_drive_sel, .g2_drive_sel, .g1_slew_fast, .g2_slew_fast,
	.g1_supply_level_select, .g2_supply_level_select);

// ===== dv/tb_top.sv
// Directed testbench for the pad configuration register bank.
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [15:0] reg_addr = 16'h0, reg_wdata = 16'h0, reg_rdata;
	logic [55:0] g1_drive_sel;
	logic [59:0] g2_drive_sel;
	logic [13:0] g1_slew_fast;
	logic [14:0] g2_slew_fast;
	logic g1_supply_level_select, g2_supply_level_select;
	int errors = 0, n_compared = 0;
	logic [15:0] p [4] = '{16'h0, 16'hffff, 16'h5a3c, 16'hc3a5};
	logic [15:0] a [6] = '{16'hfa70, 16'hfa71, 16'hfa72, 16'hfa74, 16'hfa75, 16'hfa76};
	logic [15:0] rv [6] = '{16'h0, 16'h0, 16'h0, 16'h7fff, 16'h0, 16'h0};
	gpc_pad_config_regs u_gpc_pad_config_regs (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .g1_drive_sel, .g2_drive_sel, .g1_slew_fast, .g2_slew_fast,
		.g1_supply_level_select, .g2_supply_level_select);
	initial forever #5 clk = ~clk;
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [15:0] ad, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] ad, input logic [15:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask : rd
	// Expected one-hot select of 15 pins from the low and high drive bits.
	function automatic logic [59:0] dsel(input logic [15:0] lo, input logic [15:0] hi);
		for (int i = 0; i < 15; i++) dsel[4*i+:4] = 4'h1 << {hi[i], lo[i]};
	endfunction : dsel
	task automatic final_report();
		if (errors == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : final_report
	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 6; i++) rd(a[i], rv[i]);
		chk({4'h1, g1_drive_sel}, dsel(16'h0, 16'h0));
		chk(g2_drive_sel, dsel(16'hffff, 16'h0));
		for (int k = 0; k < 4; k++) begin
			wr(a[0], p[k]);
			wr(a[1], p[3-k]);
			wr(a[3], p[k]);
			wr(a[4], p[3-k]);
			rd(a[0], p[k] & 16'h3fff);
			rd(a[1], p[3-k] & 16'h3fff);
			rd(a[4], p[3-k] & 16'h7fff);
			rd(a[3], p[k] & 16'h7fff);
			chk({4'h1, g1_drive_sel}, dsel(p[k] & 16'h3fff, p[3-k] & 16'h3fff));
			chk(g2_drive_sel, dsel(p[k], p[3-k]));
		end
		for (int k = 1; k < 3; k++) begin
			wr(a[2], p[k]);
			wr(a[5], p[k]);
			rd(a[2], p[k] & 16'hbfff);
			rd(a[5], p[k]);
			chk({g1_supply_level_select, g1_slew_fast}, {p[k][15], p[k][13:0]});
			chk({g2_supply_level_select, g2_slew_fast}, p[k]);
		end
		wr(16'hfa73, 16'hffff);
		rd(16'hfa73, 16'h0);
		rd(a[5], p[2]);
		// A reset in mid-run must bring every register back to its value after power-up.
		@(posedge clk);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 6; i++) rd(a[i], rv[i]);
		chk(g2_drive_sel, dsel(16'hffff, 16'h0));
		chk({g2_supply_level_select, g2_slew_fast}, 16'h0);
		final_report();
	end
	initial begin
		#100000;
		errors++;
		final_report();
	end
endmodule : tb_top
